// File: core/wake_reset_pkg.sv
// package: constants and types for the wake exit and reset cause block
package wake_reset_pkg;

    // register map (plain port, word index)
    localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
    localparam logic [3:0] ADDR_WAKE_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_CLK_STATUS  = 4'h2;
    localparam logic [3:0] ADDR_PIN_STATUS  = 4'h3;

    // reset cause register field positions
    localparam int BIT_PRIORITY  = 7;
    localparam int BIT_SOFT_BO   = 6;
    localparam int BIT_RESET_INS = 4;
    localparam int BIT_WDT_EXP   = 3;
    localparam int BIT_SLEEP_EX  = 2;
    localparam int BIT_POWER_ON  = 1;
    localparam int BIT_LOW_SUP   = 0;
    localparam int FLAG_BITS     = 5;

    // values after power-on
    localparam logic       PRIORITY_RESET = 1'b0;
    localparam logic [4:0] FLAGS_POR_VAL  = 5'h1C;
    localparam logic [1:0] BO_SOFT_CFG    = 2'h1;

    // timing at 10 MHz
    localparam int CLK_HZ           = 10_000_000;
    localparam int CORE_PREP_NS     = 1000;
    localparam int CORE_PREP_CYC    = (CORE_PREP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CRYSTAL_CYCLES   = 1024;
    localparam int PLL_LOCK_US      = 2000;
    localparam int PLL_LOCK_CYC     = PLL_LOCK_US * (CLK_HZ / 1_000_000);
    localparam int FAST_INTERNAL_OSCILLATOR_STAB_CYC  = 4;
    localparam int FILTER_CYC       = 4;

    // clock source selection
    typedef enum logic [2:0] {
        SRC_NONE    = 3'h0,
        SRC_CRYSTAL = 3'h1,
        SRC_PLL     = 3'h2,
        SRC_EXT_RC  = 3'h3,
        SRC_SLOW    = 3'h4,
        SRC_FAST    = 3'h5,
        SRC_TIMER   = 3'h6,
        SRC_PRIMARY = 3'h7
    } clk_src_t;

    // wake sequencer states
    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE  = 2'h2
    } wake_state_t;

endpackage : wake_reset_pkg

// File: core/pin_glitch_filter.sv
// glitch filter for the external reset pin after two-flop sync
module pin_glitch_filter #(
    parameter int FILTER_LEN = 4
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // raw pin and filtered level
    input  wire logic pin_raw,
    output logic      pin_clean
);
    typedef struct packed {
        logic       sync_a;
        logic       sync_b;
        logic [7:0] cnt;
        logic       level;
    } filt_t;

    filt_t cur;
    filt_t next_cur;

    // count stable cycles before following the synchronised pin
    always_comb begin
        next_cur        = cur;
        next_cur.sync_a = pin_raw;
        next_cur.sync_b = cur.sync_a;
        if (cur.sync_b == cur.level) begin
            next_cur.cnt = 8'h00;
        end else if (cur.cnt >= 8'(FILTER_LEN - 1)) begin
            next_cur.level = cur.sync_b;
            next_cur.cnt   = 8'h00;
        end else begin
            next_cur.cnt = cur.cnt + 8'h01;
        end
    end

    // pin idles high, so reset to the released level
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '{sync_a: 1'b1, sync_b: 1'b1, cnt: 8'h00, level: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    assign pin_clean = cur.level;
endmodule // pin_glitch_filter

// File: core/wake_exit_reset_cause.sv
// wake exit delay sequencer and reset cause register
// Behaviour
// - skip crystal wait if primary idle or non-crystal
// - fixed prep delay, fetch right after it if no crystal or pll wait
// - crystal exit waits start timer, plus pll lock
// - prep delay runs concurrent with other delays
// - fast internal target runs during stabilisation
// - slow internal target: prep delay, no status
// - eight distinct reset causes recognised
// - low five bits are event flags
// - bit 7 selects two-level interrupt priority
// - bit 6 soft brown-out, only config 01
// - reset instruction clears bit 4
// - bit 3 set power/clear/sleep, cleared watchdog
// - bit 2 set power/clear, cleared sleep
// - power-on clears bit 1, firmware sets
// - brown-out clears bit 0, firmware sets
// - pin low resets, glitches filtered
// - never drives the reset pin
// - pin disabled becomes plain input
// - power-on flag untouched by other resets
// - crystal timer counts 1024 oscillator cycles
module wake_exit_reset_cause
    import wake_reset_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = wake_reset_pkg::PLL_LOCK_CYC,
    parameter int CRYSTAL_COUNT   = wake_reset_pkg::CRYSTAL_CYCLES
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // configuration straps
    input  wire logic       external_reset_pin_enable,
    input  wire logic [1:0] low_supply_detect_config,
    // reset events, one-cycle pulses from core logic
    input  wire logic       power_on_event,
    input  wire logic       low_supply_event,
    input  wire logic       reset_instr_event,
    input  wire logic       watchdog_expiry_event,
    input  wire logic       stack_full_event,
    input  wire logic       stack_underflow_event,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       sleep_instr,
    input  wire logic       wake_event,
    // clock sources
    input  wire logic       crystal_osc_in,
    input  wire logic       fast_osc_stable_in,
    // external reset pin (three signals, never driven)
    input  wire logic       external_reset_pin_i,
    output logic            external_reset_pin_o,
    output logic            external_reset_pin_oe,
    // outputs to core
    output logic            core_reset,
    output logic            core_run,
    output logic            irq_priority_levels_on,
    output logic            soft_brownout_switch,
    output logic            pin_digital_in,
    output logic      [2:0] last_reset_cause
);
    import wake_reset_pkg::*;

    localparam logic [15:0] PREP_LEN   = 16'(CORE_PREP_CYC);
    localparam logic [15:0] CRYS_LEN   = 16'(CRYSTAL_COUNT);
    localparam logic [23:0] PLL_LEN    = 24'(PLL_LOCK_CYCLES);
    localparam logic [15:0] STAB_LEN   = 16'(FAST_INTERNAL_OSCILLATOR_STAB_CYC);

    // coarse cause codes for last_reset_cause
    localparam logic [2:0] CAUSE_POWER   = 3'h0;
    localparam logic [2:0] CAUSE_PIN_RUN = 3'h1;
    localparam logic [2:0] CAUSE_PIN_PM  = 3'h2;
    localparam logic [2:0] CAUSE_WDT     = 3'h3;
    localparam logic [2:0] CAUSE_LOWSUP  = 3'h4;
    localparam logic [2:0] CAUSE_INSTR   = 3'h5;
    localparam logic [2:0] CAUSE_SFULL   = 3'h6;
    localparam logic [2:0] CAUSE_SUNDER  = 3'h7;

    typedef struct packed {
        logic        priority_on;
        logic        soft_bo;
        logic [4:0]  flags;
        logic [2:0]  cause;
        wake_state_t state;
        clk_src_t    src_before;
        clk_src_t    src_after;
        logic        prim_idle;
        logic [15:0] prep_cnt;
        logic        prep_done;
        logic [15:0] crys_cnt;
        logic        crys_done;
        logic [23:0] pll_cnt;
        logic        pll_done;
        logic [15:0] stab_cnt;
        logic        crystal_ready_status;
        logic        internal_osc_stable_status;
        logic        pin_reset;
        logic [1:0]  osc_sync;
        logic        osc_prev;
        logic [1:0]  stab_sync;
        logic [7:0]  rdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic   pin_clean;

    // filters short glitches on the synchronised pin level
    pin_glitch_filter #(
        .FILTER_LEN (FILTER_CYC)
    ) u_filter (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .pin_raw   (external_reset_pin_i),
        .pin_clean (pin_clean)
    );

    // whether a target source needs the crystal timer
    function automatic logic needs_crystal(input clk_src_t s);
        needs_crystal = (s == SRC_CRYSTAL) || (s == SRC_PLL);
    endfunction

    // next main state
    always_comb begin
        logic osc_edge;
        logic pin_rst;
        osc_edge = 1'b0;
        pin_rst  = 1'b0;
        next_cur = cur;

        // two-flop sync of external oscillator and stable level
        next_cur.osc_sync  = {cur.osc_sync[0], crystal_osc_in};
        next_cur.osc_prev  = cur.osc_sync[1];
        osc_edge           = cur.osc_sync[1] & ~cur.osc_prev;
        next_cur.stab_sync = {cur.stab_sync[0], fast_osc_stable_in};

        // pin reset only while enabled and filtered low
        pin_rst = external_reset_pin_enable & ~pin_clean;
        next_cur.pin_reset = pin_rst;

        // firmware writes only set flags
        if (reg_wr) begin
            case (reg_addr)
                ADDR_RESET_CAUSE: begin
                    next_cur.priority_on = reg_wdata[BIT_PRIORITY];
                    if (low_supply_detect_config == BO_SOFT_CFG) begin
                        next_cur.soft_bo = reg_wdata[BIT_SOFT_BO];
                    end
                    next_cur.flags[BIT_RESET_INS] = cur.flags[BIT_RESET_INS]
                        | reg_wdata[BIT_RESET_INS];
                    next_cur.flags[BIT_POWER_ON] = cur.flags[BIT_POWER_ON]
                        | reg_wdata[BIT_POWER_ON];
                    next_cur.flags[BIT_LOW_SUP] = cur.flags[BIT_LOW_SUP]
                        | reg_wdata[BIT_LOW_SUP];
                end
                ADDR_WAKE_CTRL: begin
                    next_cur.src_before = clk_src_t'(reg_wdata[2:0]);
                    next_cur.src_after  = clk_src_t'(reg_wdata[5:3]);
                    next_cur.prim_idle  = reg_wdata[6];
                end
                default: begin
                end
            endcase
        end

        // hardware events override a same-cycle write
        if (watchdog_clear_instr) begin
            next_cur.flags[BIT_WDT_EXP]  = 1'b1;
            next_cur.flags[BIT_SLEEP_EX] = 1'b1;
        end
        if (sleep_instr) begin
            next_cur.flags[BIT_WDT_EXP]  = 1'b1;
            next_cur.flags[BIT_SLEEP_EX] = 1'b0;
        end
        if (watchdog_expiry_event) begin
            next_cur.flags[BIT_WDT_EXP] = 1'b0;
        end
        if (reset_instr_event) begin
            next_cur.flags[BIT_RESET_INS] = 1'b0;
        end
        if (low_supply_event) begin
            next_cur.flags[BIT_LOW_SUP] = 1'b0;
        end
        // power-on flag changes only here and by firmware
        if (power_on_event) begin
            next_cur.flags       = FLAGS_POR_VAL;
            next_cur.priority_on = PRIORITY_RESET;
            next_cur.soft_bo     = (low_supply_detect_config == BO_SOFT_CFG);
        end
        if (low_supply_detect_config != BO_SOFT_CFG) begin
            next_cur.soft_bo = 1'b0;
        end

        // record the most recent cause, eight kinds
        if (power_on_event) begin
            next_cur.cause = CAUSE_POWER;
        end else if (low_supply_event) begin
            next_cur.cause = CAUSE_LOWSUP;
        end else if (pin_rst & ~cur.pin_reset) begin
            next_cur.cause = (cur.state == ST_RUN) ? CAUSE_PIN_RUN : CAUSE_PIN_PM;
        end else if (watchdog_expiry_event && cur.state == ST_RUN) begin
            next_cur.cause = CAUSE_WDT;
        end else if (reset_instr_event) begin
            next_cur.cause = CAUSE_INSTR;
        end else if (stack_full_event) begin
            next_cur.cause = CAUSE_SFULL;
        end else if (stack_underflow_event) begin
            next_cur.cause = CAUSE_SUNDER;
        end

        // wake sequencer: prep and crystal timers start at the wake event, pll lock after the crystal
        case (cur.state)
            ST_RUN: begin
                if (sleep_instr) begin
                    next_cur.state = ST_SLEEP;
                    if (!cur.prim_idle) begin
                        next_cur.crystal_ready_status = 1'b0;
                    end
                end
            end
            ST_SLEEP: begin
                if (wake_event || (watchdog_expiry_event)) begin
                    next_cur.state     = ST_WAKE;
                    next_cur.prep_cnt  = 16'h0000;
                    next_cur.prep_done = 1'b0;
                    next_cur.crys_cnt  = 16'h0000;
                    next_cur.pll_cnt   = 24'h000000;
                    next_cur.stab_cnt  = 16'h0000;
                    // skip crystal wait if clock kept running or not a crystal
                    next_cur.crys_done = cur.prim_idle
                        || !needs_crystal(cur.src_after);
                    next_cur.pll_done  = cur.prim_idle
                        || (cur.src_after != SRC_PLL);
                    // fast internal back into itself: no stabilisation wait
                    if (cur.src_after == SRC_FAST && cur.src_before == SRC_FAST) begin
                        next_cur.internal_osc_stable_status = 1'b1;
                    end else if (cur.src_after == SRC_FAST && !cur.prim_idle) begin
                        next_cur.internal_osc_stable_status = 1'b0;
                    end
                end
            end
            ST_WAKE: begin
                // prep delay counts in parallel with others
                if (cur.prep_cnt >= PREP_LEN - 16'h0001) begin
                    next_cur.prep_done = 1'b1;
                end else begin
                    next_cur.prep_cnt = cur.prep_cnt + 16'h0001;
                end
                if (!cur.crys_done && osc_edge) begin
                    if (cur.crys_cnt >= CRYS_LEN - 16'h0001) begin
                        next_cur.crys_done = 1'b1;
                    end else begin
                        next_cur.crys_cnt = cur.crys_cnt + 16'h0001;
                    end
                end
                if (cur.crys_done && !cur.pll_done) begin
                    if (cur.pll_cnt >= PLL_LEN - 24'h000001) begin
                        next_cur.pll_done = 1'b1;
                    end else begin
                        next_cur.pll_cnt = cur.pll_cnt + 24'h000001;
                    end
                end
                // execution resumes right after every needed delay
                if (cur.prep_done && cur.crys_done && cur.pll_done) begin
                    next_cur.state = ST_RUN;
                end
            end
            default: begin
                next_cur.state = ST_RUN;
            end
        endcase

        // crystal ready once the timer ends on a crystal target
        if (cur.state == ST_WAKE && needs_crystal(cur.src_after) && cur.crys_done) begin
            next_cur.crystal_ready_status = 1'b1;
        end
        // fast internal stable on the synced stable input or after the stabilisation interval; slow has none
        if (cur.src_after == SRC_FAST && !cur.internal_osc_stable_status) begin
            if (cur.stab_sync[1] || cur.stab_cnt >= STAB_LEN - 16'h0001) begin
                next_cur.internal_osc_stable_status = 1'b1;
            end else begin
                next_cur.stab_cnt = cur.stab_cnt + 16'h0001;
            end
        end
        if (cur.src_after == SRC_SLOW) begin
            next_cur.internal_osc_stable_status = 1'b0;
        end

        // registered read data, one cycle after the strobe
        next_cur.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_RESET_CAUSE: next_cur.rdata = {cur.priority_on,
                    cur.soft_bo & (low_supply_detect_config == BO_SOFT_CFG),
                    1'b0, cur.flags};
                ADDR_WAKE_CTRL:   next_cur.rdata = {1'b0, cur.prim_idle,
                    cur.src_after, cur.src_before};
                ADDR_CLK_STATUS:  next_cur.rdata = {3'h0, cur.state,
                    cur.cause[0], cur.crystal_ready_status,
                    cur.internal_osc_stable_status};
                ADDR_PIN_STATUS:  next_cur.rdata = {6'h00,
                    pin_clean, cur.pin_reset};
                default:          next_cur.rdata = 8'h00;
            endcase
        end
    end

    // single state register, constant reset values only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '{priority_on: PRIORITY_RESET, soft_bo: 1'b0,
                     flags: FLAGS_POR_VAL, cause: CAUSE_POWER, state: ST_RUN,
                     src_before: SRC_NONE, src_after: SRC_EXT_RC,
                     prim_idle: 1'b0, prep_cnt: 16'h0000, prep_done: 1'b0,
                     crys_cnt: 16'h0000, crys_done: 1'b0, pll_cnt: 24'h000000,
                     pll_done: 1'b0, stab_cnt: 16'h0000,
                     crystal_ready_status: 1'b0,
                     internal_osc_stable_status: 1'b0, pin_reset: 1'b0,
                     osc_sync: 2'h0, osc_prev: 1'b0, stab_sync: 2'h0,
                     rdata: 8'h00};
        end else begin
            cur <= next_cur;
        end
    end

    // outputs
    assign reg_rdata              = cur.rdata;
    assign external_reset_pin_o   = 1'b0;
    assign external_reset_pin_oe  = 1'b0;
    assign core_reset             = cur.pin_reset;
    assign core_run               = (cur.state == ST_RUN) & ~cur.pin_reset;
    assign irq_priority_levels_on = cur.priority_on;
    assign soft_brownout_switch   = cur.soft_bo;
    assign pin_digital_in         = external_reset_pin_enable ? 1'b1 : pin_clean;
    assign last_reset_cause       = cur.cause;
endmodule // wake_exit_reset_cause

// File: tb/wake_exit_reset_cause_properties.sv
// concurrent checks on the wake exit and reset cause block ports
module wake_exit_reset_cause_properties
    import wake_reset_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // straps and events
    input wire logic       external_reset_pin_enable,
    input wire logic [1:0] low_supply_detect_config,
    input wire logic       power_on_event,
    input wire logic       low_supply_event,
    input wire logic       reset_instr_event,
    input wire logic       watchdog_expiry_event,
    input wire logic       wake_event,
    // pin and core side
    input wire logic       external_reset_pin_i,
    input wire logic       external_reset_pin_oe,
    input wire logic       core_reset,
    input wire logic       core_run,
    input wire logic       irq_priority_levels_on,
    input wire logic       soft_brownout_switch,
    input wire logic [2:0] last_reset_cause
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // the pin is never driven
    pin_never_driven_a: assert property (!external_reset_pin_oe)
        else $error("reset pin output enable raised");
    // registered reset lags the strap by one cycle
    pin_disabled_inert_a: assert property (
        !external_reset_pin_enable && !$past(external_reset_pin_enable) |-> !core_reset)
        else $error("disabled pin caused a reset");
    // short pulses die in the filter
    glitch_filter_a: assert property (
        $rose(core_reset) |-> !$past(external_reset_pin_i, 3) && !$past(external_reset_pin_i, 4))
        else $error("reset rose without a held low pin");
    pin_reset_a: assert property (
        (external_reset_pin_enable && !external_reset_pin_i) [*8] |-> ##[0:3] core_reset)
        else $error("held low pin gave no reset");
    // prep delay precedes the first fetch
    prep_wait_a: assert property (
        (wake_event || watchdog_expiry_event) && !core_run && !core_reset |=> !core_run [*8])
        else $error("core ran before the preparation delay");
    prio_write_a: assert property (
        reg_wr && reg_addr == ADDR_RESET_CAUSE && !power_on_event
        |=> irq_priority_levels_on == $past(reg_wdata[BIT_PRIORITY]))
        else $error("priority enable did not follow the write");
    soft_gate_a: assert property (
        low_supply_detect_config != BO_SOFT_CFG
        && $past(low_supply_detect_config) != BO_SOFT_CFG |-> !soft_brownout_switch)
        else $error("soft brown-out switch on outside its mode");
    cause_read_a: assert property (
        reg_rd && reg_addr == ADDR_RESET_CAUSE && low_supply_detect_config != BO_SOFT_CFG
        |=> reg_rdata[6:5] == 2'b00)
        else $error("cause bits 6:5 read as one");
    instr_cause_a: assert property (reset_instr_event |=> last_reset_cause == 3'h5)
        else $error("reset instruction cause wrong");
    low_cause_a: assert property (low_supply_event |=> last_reset_cause == 3'h4)
        else $error("brown-out cause wrong");
endmodule // wake_exit_reset_cause_properties

bind wake_exit_reset_cause wake_exit_reset_cause_properties
    wake_exit_reset_cause_properties_inst (.*);

// File: tb/reset_pin_partner.sv
// board side: pulled-up reset pin and clock sources
module reset_pin_partner (
    // request from the bench to pull the pin down
    input  wire logic hold_low,
    // device side of the pin
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_i,
    // clock sources
    output logic      crystal_osc,
    output logic      fast_stable
);
    timeunit 1ns;
    timeprecision 1ns;

    // pull-up: low only while some party pulls it down
    assign pin_i = !(hold_low || (pin_oe && !pin_o));
    // 1 us crystal, offset from the system clock
    initial begin
        crystal_osc = 1'b0;
        #37;
        forever #500 crystal_osc = ~crystal_osc;
    end
    // settles at 2 us, before the wake checks, so the stable input ends the wait
    initial begin
        fast_stable = 1'b0;
        #2000 fast_stable = 1'b1;
    end
endmodule // reset_pin_partner

// File: tb/test_wake_exit_reset_cause.sv
// self-checking bench for the wake exit and reset cause block
module test_wake_exit_reset_cause;
    timeunit 1ns;
    timeprecision 1ns;
    import wake_reset_pkg::*;

    logic       sys_clk, nrst, reg_wr, reg_rd, pin_en, hold_low, osc, fast_ok;
    logic       pin_i, pin_o, pin_oe, core_reset, core_run, prio, soft_bo, pin_dig;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] bo_cfg;
    logic [8:0] ev;
    logic [2:0] cause;
    int         err_count, checked;
    // event under test, expected flags and cause
    int         ev_sel [6] = '{1, 2, 3, 4, 5, 0};
    logic [7:0] ev_flg [6] = '{8'h1E, 8'h0F, 8'h17, 8'h1F, 8'h1F, 8'h1C};
    logic [2:0] ev_cau [6] = '{3'h4, 3'h5, 3'h3, 3'h6, 3'h7, 3'h0};
    // wake control {idle, after, before}, wake source, delay window, status
    logic [6:0] wk_ctl [7] = '{7'h1C, 7'h08, 7'h16, 7'h4F, 7'h2C, 7'h2D, 7'h20};
    int         wk_ev  [7] = '{8, 8, 3, 8, 8, 8, 8};
    int         wk_lo  [7] = '{8, 30, 38, 8, 8, 0, 8};
    int         wk_hi  [7] = '{13, 60, 75, 13, 13, 13, 13};
    logic [7:0] wk_st  [7] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h01, 8'h01, 8'h00};

    // short counts keep the run brief
    wake_exit_reset_cause #(.PLL_LOCK_CYCLES(8), .CRYSTAL_COUNT(4)) wake_exit_reset_cause_inst (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_reset_pin_enable(pin_en), .low_supply_detect_config(bo_cfg),
        .power_on_event(ev[0]), .low_supply_event(ev[1]), .reset_instr_event(ev[2]),
        .watchdog_expiry_event(ev[3]), .stack_full_event(ev[4]),
        .stack_underflow_event(ev[5]), .watchdog_clear_instr(ev[6]), .sleep_instr(ev[7]),
        .wake_event(ev[8]), .crystal_osc_in(osc), .fast_osc_stable_in(fast_ok),
        .external_reset_pin_i(pin_i), .external_reset_pin_o(pin_o),
        .external_reset_pin_oe(pin_oe), .core_reset(core_reset), .core_run(core_run),
        .irq_priority_levels_on(prio), .soft_brownout_switch(soft_bo),
        .pin_digital_in(pin_dig), .last_reset_cause(cause));

    reset_pin_partner reset_pin_partner_inst (
        .hold_low(hold_low), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
        .crystal_osc(osc), .fast_stable(fast_ok));

    // 10 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk((reg_rdata & m) === (e & m), "register read");
        @(posedge sys_clk);
    endtask

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev[i] <= 1'b0;
        @(posedge sys_clk);
    endtask

    // firmware puts every flag back to one
    task automatic restore();
        wr(ADDR_RESET_CAUSE, 8'h13);
        pulse(6);
    endtask

    // bounded wait for the core to run again
    task automatic wait_run(input int lo, input int hi);
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n >= lo && n <= hi, "wake delay out of range");
        if (n >= 2000) test_done();
        @(posedge sys_clk);
    endtask

    task automatic wake_chk(input int k);
        wr(ADDR_WAKE_CTRL, {1'b0, wk_ctl[k]});
        pulse(7);
        rd_chk(ADDR_RESET_CAUSE, 8'h08, 8'h0C);
        ev[wk_ev[k]] <= 1'b1;
        @(posedge sys_clk);
        ev[wk_ev[k]] <= 1'b0;
        wait_run(wk_lo[k], wk_hi[k]);
        rd_chk(ADDR_CLK_STATUS, wk_st[k], wk_st[k]);
    endtask

    // pin held low well past the filter
    task automatic pin_low(input logic [2:0] c);
        hold_low <= 1'b1;
        repeat (12) @(posedge sys_clk);
        #1;
        chk(core_reset === 1'b1 && core_run === 1'b0 && cause === c, "pin reset");
        rd_chk(ADDR_PIN_STATUS, 8'h01, 8'h03);
        hold_low <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk(core_reset === 1'b0, "pin reset stuck");
    endtask

    initial begin
        nrst = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pin_en = 1'b1;
        bo_cfg = 2'h0;
        ev = 9'h000;
        hold_low = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        // reset value, control bits and read-only flags
        rd_chk(ADDR_RESET_CAUSE, 8'h1C, 8'hFF);
        wr(ADDR_RESET_CAUSE, 8'hD3);
        rd_chk(ADDR_RESET_CAUSE, 8'h9F, 8'hFF);
        chk(prio === 1'b1 && soft_bo === 1'b0, "control bits");
        bo_cfg <= BO_SOFT_CFG;
        wr(ADDR_RESET_CAUSE, 8'h53);
        rd_chk(ADDR_RESET_CAUSE, 8'h5F, 8'hFF);
        chk(prio === 1'b0 && soft_bo === 1'b1, "control bits");
        pulse(0);
        chk(soft_bo === 1'b1, "soft switch after power-on");
        bo_cfg <= 2'h3;
        rd_chk(ADDR_RESET_CAUSE, 8'h1C, 8'hFF);
        rd_chk(4'hF, 8'h00, 8'hFF);
        // each reset event against the flags
        for (int k = 0; k < 6; k++) begin
            restore();
            pulse(ev_sel[k]);
            chk(cause === ev_cau[k], "reset cause");
            rd_chk(ADDR_RESET_CAUSE, ev_flg[k], 8'hFF);
        end
        // wake delays by source before and after
        for (int k = 0; k < 7; k++) begin
            wake_chk(k);
        end
        // short glitch must not reach the core
        hold_low <= 1'b1;
        repeat (2) @(posedge sys_clk);
        hold_low <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(core_reset === 1'b0, "glitch reached reset");
        pin_low(3'h1);
        pulse(7);
        pin_low(3'h2);
        // disabled pin is a plain input
        pin_en <= 1'b0;
        hold_low <= 1'b1;
        repeat (12) @(posedge sys_clk);
        #1;
        chk(core_reset === 1'b0 && pin_dig === 1'b0, "disabled pin low");
        hold_low <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk(pin_dig === 1'b1, "disabled pin high");
        test_done();
    end
endmodule // test_wake_exit_reset_cause
